// ===== hdl/plm_pkg.sv
// plm_pkg: shared constants and types for the indicator and gpio pin mux
// assumes: a 32-bit axi4-lite register port and one core clock
package plm_pkg;
	localparam int CLK_MHZ = 200;
	localparam int BLINK_MS = 50;
	localparam int BLINK_CYCLES = BLINK_MS * 1000 * CLK_MHZ;
	localparam logic [7:0] ADDR_FUNC = 8'h00;
	localparam logic [7:0] ADDR_GPIO_OUT = 8'h04;
	localparam logic [7:0] ADDR_GPIO_OE = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_LINE = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// function select codes
	localparam logic [1:0] LNK_LINK = 2'h0;
	localparam logic [1:0] LNK_ACT = 2'h1;
	localparam logic [1:0] SPD_TRI = 2'h0;
	localparam logic [1:0] SPD_SPEED = 2'h1;
	localparam logic [1:0] SPD_GPIO = 2'h2;
	localparam logic [1:0] COL_COLL = 2'h0;
	localparam logic [1:0] COL_LED = 2'h1;
	localparam logic [1:0] COL_GPIO = 2'h2;
	localparam logic [1:0] RXD_DATA = 2'h0;
	localparam logic [1:0] RXD_LED = 2'h1;
	localparam logic [1:0] RXD_GPIO = 2'h2;
	// mac interface modes
	localparam logic [1:0] MAC_MII = 2'h0;
	localparam logic [1:0] MAC_RMII = 2'h1;
	localparam logic [1:0] MAC_RGMII = 2'h2;
	// line mode request / result
	localparam logic [1:0] LINE_AUTO = 2'h0;
	localparam logic [1:0] LINE_10T = 2'h1;
	localparam logic [1:0] LINE_100TX = 2'h2;
	localparam logic [1:0] LINE_100FX = 2'h3;
	localparam int FLD_LNK = 0;
	localparam int FLD_SPD = 2;
	localparam int FLD_COL = 4;
	localparam int FLD_RXD = 6;
	localparam int FLD_LINE = 0;
	// msb first, so lnk lands in bits 1:0 as the field positions say
	typedef struct packed {
		logic [1:0] rxd;
		logic [1:0] col;
		logic [1:0] spd;
		logic [1:0] lnk;
	} plm_func_t;
	typedef struct packed {
		logic linkUp;
		logic speed100;
		logic fullDuplex;
		logic txActive;
		logic rxActive;
		logic fxDetect;
	} plm_phy_t;
	typedef enum logic [2:0] {
		BL_IDLE = 3'b001,
		BL_OFF = 3'b010,
		BL_ON = 3'b100
	} plm_blink_t;
endpackage

// ===== hdl/plm_sync.sv
// plm_sync: three-stage synchroniser for a pin input
// assumes: pin is asynchronous to core_clk
`timescale 1ns/100ps
`default_nettype none
module plm_sync (
	// clock
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clkEn,
	// data
	input wire logic pinIn,
	output logic level
);
	logic s1, s2, s3;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else if (clkEn) begin
			s1 <= pinIn;
			s2 <= s1;
			s3 <= s2;
		end
	end
	// level moves only once stages two and three agree
	always_ff @(posedge core_clk) begin
		if (reset)
			level <= 1'b0;
		else if (clkEn && s2 == s3)
			level <= s3;
	end
endmodule
`default_nettype wire

// ===== hdl/plm_pin_mux.sv
// plm_pin_mux: indicator, gpio and line-mode selection for a 10/100 phy
// assumes: phy status from the core on core_clk; pins split into in/out/oe
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module plm_pin_mux #(
	parameter int BLINK_HALF = plm_pkg::BLINK_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clkEn,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// phy core status and straps
	input wire plm_pkg::plm_phy_t phy,
	input wire logic [1:0] macMode,
	input wire logic [1:0] autoLine,
	input wire plm_pkg::plm_func_t strapFunc,
	input wire logic rxData3,
	// pins
	output logic link_indicator_pin,
	input wire logic speed_indicator_pin_in,
	output logic speed_indicator_pin_out,
	output logic speed_indicator_pin_oe,
	input wire logic colPinIn,
	output logic colPinOut,
	output logic colPinOe,
	input wire logic rxd3PinIn,
	output logic rxd3PinOut,
	output logic rxd3PinOe,
	// media line selection and signal detect
	output logic [1:0] lineMode,
	output logic signalDetect
);
	plm_pkg::plm_func_t func;
	logic [2:0] gpioOut, gpioOe, gpioIn;
	logic [1:0] lineReq;
	logic strapDone;
	logic awHeld, wHeld;
	logic [7:0] awAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;
	logic fxMode, blinkLed, collision;
	plm_pkg::plm_blink_t blinkState;
	logic [31:0] blinkCnt;
	logic [31:0] rdWord;
	logic rdOk;

	function automatic logic mapped(input logic [7:0] a);
		return a == plm_pkg::ADDR_FUNC || a == plm_pkg::ADDR_GPIO_OUT ||
			a == plm_pkg::ADDR_GPIO_OE || a == plm_pkg::ADDR_STATUS ||
			a == plm_pkg::ADDR_LINE;
	endfunction

	// three pin inputs go through the same synchroniser
	plm_sync uSyncSpd (.core_clk(core_clk), .reset(reset), .clkEn(clkEn),
		.pinIn(speed_indicator_pin_in), .level(gpioIn[0]));
	plm_sync uSyncCol (.core_clk(core_clk), .reset(reset), .clkEn(clkEn),
		.pinIn(colPinIn), .level(gpioIn[1]));
	plm_sync uSyncRxd (.core_clk(core_clk), .reset(reset), .clkEn(clkEn),
		.pinIn(rxd3PinIn), .level(gpioIn[2]));

	// write address and data may arrive in either order
	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready = !wHeld && !s_axi_bvalid;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			awHeld <= 1'b0;
			awAddr <= 8'h00;
		end else if (clkEn) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end else if (awHeld && wHeld) begin
				awHeld <= 1'b0;
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (reset) begin
			wHeld <= 1'b0;
			wData <= 32'h0000_0000;
			wStrb <= 4'h0;
		end else if (clkEn) begin
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end else if (awHeld && wHeld) begin
				wHeld <= 1'b0;
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= plm_pkg::RESP_OKAY;
		end else if (clkEn) begin
			if (awHeld && wHeld) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(awAddr) ? plm_pkg::RESP_OKAY : plm_pkg::RESP_DECERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// strap caught in the first enabled cycle after reset, then software owns it
	always_ff @(posedge core_clk) begin
		if (reset) begin
			strapDone <= 1'b0;
			func <= '0;
		end else if (clkEn) begin
			if (!strapDone) begin
				strapDone <= 1'b1;
				func <= strapFunc;
			end else if (awHeld && wHeld && awAddr == plm_pkg::ADDR_FUNC && wStrb[0]) begin
				func <= plm_pkg::plm_func_t'(wData[7:0]);
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (reset) begin
			gpioOut <= 3'h0;
			gpioOe <= 3'h0;
			lineReq <= plm_pkg::LINE_AUTO;
		end else if (clkEn && awHeld && wHeld && wStrb[0]) begin
			if (awAddr == plm_pkg::ADDR_GPIO_OUT)
				gpioOut <= wData[2:0];
			if (awAddr == plm_pkg::ADDR_GPIO_OE)
				gpioOe <= wData[2:0];
			if (awAddr == plm_pkg::ADDR_LINE)
				lineReq <= wData[plm_pkg::FLD_LINE +: 2];
		end
	end

	// read channel: one-cycle answer, held until rready
	assign s_axi_arready = !s_axi_rvalid;
	always_comb begin
		rdWord = 32'h0000_0000;
		rdOk = 1'b1;
		case (s_axi_araddr)
			plm_pkg::ADDR_FUNC: rdWord[7:0] = func;
			plm_pkg::ADDR_GPIO_OUT: rdWord[2:0] = gpioOut;
			plm_pkg::ADDR_GPIO_OE: rdWord[2:0] = gpioOe;
			plm_pkg::ADDR_STATUS: rdWord = {24'h000000, signalDetect, lineMode, gpioIn,
				phy.linkUp, phy.speed100};
			plm_pkg::ADDR_LINE: rdWord[1:0] = lineReq;
			default: rdOk = 1'b0;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= plm_pkg::RESP_OKAY;
		end else if (clkEn) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdWord;
				s_axi_rresp <= rdOk ? plm_pkg::RESP_OKAY : plm_pkg::RESP_DECERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// line mode: forced request wins, else follows negotiation
	always_ff @(posedge core_clk) begin
		if (reset)
			lineMode <= plm_pkg::LINE_AUTO;
		else if (clkEn)
			lineMode <= (lineReq == plm_pkg::LINE_AUTO) ? autoLine : lineReq;
	end
	assign fxMode = lineMode == plm_pkg::LINE_100FX;

	// blink: one off/on cycle of fixed length each time activity is seen while idle
	always_ff @(posedge core_clk) begin
		if (reset) begin
			blinkState <= plm_pkg::BL_IDLE;
			blinkCnt <= 32'h0000_0000;
		end else if (clkEn) begin
			case (blinkState)
				plm_pkg::BL_IDLE: begin
					blinkCnt <= 32'h0000_0000;
					if (phy.txActive || phy.rxActive)
						blinkState <= plm_pkg::BL_OFF;
				end
				plm_pkg::BL_OFF, plm_pkg::BL_ON: begin
					if (blinkCnt == 32'(BLINK_HALF - 1)) begin
						blinkCnt <= 32'h0000_0000;
						blinkState <= (blinkState == plm_pkg::BL_OFF) ? plm_pkg::BL_ON :
							plm_pkg::BL_IDLE;
					end else begin
						blinkCnt <= blinkCnt + 32'h0000_0001;
					end
				end
				default: blinkState <= plm_pkg::BL_IDLE;
			endcase
		end
	end
	assign blinkLed = blinkState != plm_pkg::BL_OFF;

	assign collision = !phy.fullDuplex && phy.txActive && phy.rxActive;

	// pin outputs registered; rx data three keeps data unless rmii
	always_ff @(posedge core_clk) begin
		if (reset) begin
			link_indicator_pin <= 1'b0;
			speed_indicator_pin_out <= 1'b0;
			speed_indicator_pin_oe <= 1'b0;
			colPinOut <= 1'b0;
			colPinOe <= 1'b0;
			rxd3PinOut <= 1'b0;
			rxd3PinOe <= 1'b0;
			signalDetect <= 1'b0;
		end else if (clkEn) begin
			if (func.lnk == plm_pkg::LNK_ACT)
				link_indicator_pin <= phy.linkUp && blinkLed;
			else
				link_indicator_pin <= phy.linkUp;
			signalDetect <= fxMode && gpioIn[0];
			if (fxMode) begin
				speed_indicator_pin_oe <= 1'b0;
				speed_indicator_pin_out <= 1'b0;
			end else if (func.spd == plm_pkg::SPD_SPEED) begin
				speed_indicator_pin_oe <= 1'b1;
				speed_indicator_pin_out <= phy.linkUp && phy.speed100;
			end else if (func.spd == plm_pkg::SPD_GPIO) begin
				speed_indicator_pin_oe <= gpioOe[0];
				speed_indicator_pin_out <= gpioOut[0];
			end else begin
				speed_indicator_pin_oe <= 1'b0;
				speed_indicator_pin_out <= 1'b0;
			end
			if (func.col == plm_pkg::COL_GPIO) begin
				colPinOe <= gpioOe[1];
				colPinOut <= gpioOut[1];
			end else if (func.col == plm_pkg::COL_LED &&
				((macMode == plm_pkg::MAC_MII && phy.fullDuplex) || macMode != plm_pkg::MAC_MII)) begin
				colPinOe <= 1'b1;
				colPinOut <= phy.linkUp;
			end else begin
				colPinOe <= 1'b1;
				colPinOut <= collision;
			end
			if (macMode != plm_pkg::MAC_RMII) begin
				rxd3PinOe <= 1'b1;
				rxd3PinOut <= rxData3;
			end else if (func.rxd == plm_pkg::RXD_LED) begin
				rxd3PinOe <= 1'b1;
				rxd3PinOut <= phy.linkUp && blinkLed;
			end else if (func.rxd == plm_pkg::RXD_GPIO) begin
				rxd3PinOe <= gpioOe[2];
				rxd3PinOut <= gpioOut[2];
			end else begin
				rxd3PinOe <= 1'b0;
				rxd3PinOut <= 1'b0;
			end
		end
	end

	// checks
	sequence s_write_done;
		awHeld && wHeld ##1 s_axi_bvalid;
	endsequence
	a_link_default: assert property (@(posedge core_clk) disable iff (reset)
		clkEn && strapDone && func.lnk == plm_pkg::LNK_LINK ##1 1'b1 |->
		link_indicator_pin == $past(phy.linkUp)) else $error("link pin wrong");
	a_act_off: assert property (@(posedge core_clk) disable iff (reset)
		clkEn && !phy.linkUp |=> !link_indicator_pin) else $error("act led lit w/o link");
	a_speed_tristate: assert property (@(posedge core_clk) disable iff (reset)
		clkEn && func.spd == plm_pkg::SPD_TRI |=> !speed_indicator_pin_oe)
		else $error("speed pin driven");
	a_speed_led: assert property (@(posedge core_clk) disable iff (reset)
		clkEn && !fxMode && func.spd == plm_pkg::SPD_SPEED |=>
		speed_indicator_pin_out == $past(phy.linkUp && phy.speed100)) else $error("speed led");
	a_fx_input: assert property (@(posedge core_clk) disable iff (reset)
		clkEn && fxMode |=> !speed_indicator_pin_oe) else $error("fx pin driven");
	a_rxd_keep: assert property (@(posedge core_clk) disable iff (reset)
		clkEn && macMode != plm_pkg::MAC_RMII |=> rxd3PinOe && rxd3PinOut == $past(rxData3))
		else $error("rxd3 reassigned");
	a_col_full: assert property (@(posedge core_clk) disable iff (reset)
		clkEn && func.col == plm_pkg::COL_COLL && phy.fullDuplex |=> !colPinOut)
		else $error("collision in full duplex");
	a_line_force: assert property (@(posedge core_clk) disable iff (reset)
		clkEn && lineReq != plm_pkg::LINE_AUTO |=> lineMode == $past(lineReq))
		else $error("line not forced");
	a_write_resp: assert property (@(posedge core_clk) disable iff (reset)
		clkEn && awHeld && wHeld |-> s_write_done) else $error("no write response");
	a_spd_gpio: assert property (@(posedge core_clk) disable iff (reset)
		clkEn && !fxMode && func.spd == plm_pkg::SPD_GPIO |=>
		speed_indicator_pin_oe == $past(gpioOe[0]) &&
		speed_indicator_pin_out == $past(gpioOut[0])) else $error("speed gpio wrong");
	a_col_gpio: assert property (@(posedge core_clk) disable iff (reset)
		clkEn && func.col == plm_pkg::COL_GPIO |=>
		colPinOe == $past(gpioOe[1]) && colPinOut == $past(gpioOut[1]))
		else $error("col gpio wrong");
	a_col_led: assert property (@(posedge core_clk) disable iff (reset)
		clkEn && func.col == plm_pkg::COL_LED && (macMode != plm_pkg::MAC_MII || phy.fullDuplex)
		|=> colPinOe && colPinOut == $past(phy.linkUp)) else $error("col led wrong");
	a_rxd_led: assert property (@(posedge core_clk) disable iff (reset)
		clkEn && macMode == plm_pkg::MAC_RMII && func.rxd == plm_pkg::RXD_LED |=>
		rxd3PinOe && rxd3PinOut == $past(phy.linkUp && blinkLed)) else $error("rxd led wrong");
	a_rxd_gpio: assert property (@(posedge core_clk) disable iff (reset)
		clkEn && macMode == plm_pkg::MAC_RMII && func.rxd == plm_pkg::RXD_GPIO |=>
		rxd3PinOe == $past(gpioOe[2]) && rxd3PinOut == $past(gpioOut[2]))
		else $error("rxd gpio wrong");
	a_strap_load: assert property (@(posedge core_clk) disable iff (reset)
		clkEn && !strapDone |=> strapDone && func == $past(strapFunc)) else $error("strap lost");
	a_blink_half: assert property (@(posedge core_clk) disable iff (reset)
		clkEn && blinkState == plm_pkg::BL_OFF && blinkCnt == 32'(BLINK_HALF - 1) |=>
		blinkState == plm_pkg::BL_ON && blinkCnt == 32'h0000_0000) else $error("blink half wrong");
endmodule
`default_nettype wire

// ===== tb/plm_board.sv
// plm_board: board side of the muxed pins, with strap pulls and optical detect
// assumes: each pin arrives from the mux split into out and oe
`timescale 1ns/100ps
`default_nettype none
module plm_board (
	// pins from the mux
	input wire logic spdOut,
	input wire logic spdOe,
	input wire logic colOut,
	input wire logic colOe,
	input wire logic rxdOut,
	input wire logic rxdOe,
	// optical transceiver
	input wire logic fibre,
	input wire logic sdLevel,
	// resolved wire levels
	output logic spdWire,
	output logic colWire,
	output logic rxdWire
);
	// released pins fall to their pulls or, for the speed pin with fibre set, to sdLevel; never to the last driven value
	assign spdWire = spdOe ? spdOut : (fibre ? sdLevel : 1'b0);
	assign colWire = colOe ? colOut : 1'b1;
	assign rxdWire = rxdOe ? rxdOut : 1'b0;
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// tb_top: self-checking bench comparing the pin mux with a bench model
// assumes: hdl package and mux compiled first, plm_board beside it
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic core_clk = 0, reset = 1, awV = 0, wV = 0, bR = 0, arV = 0, rR = 0, en = 1;
	logic [7:0] awA = 8'h00, arA = 8'h00;
	logic [31:0] wD = 32'h0, rD;
	logic awRdy, wRdy, bV, arRdy, rV, sdet, lnkPin, spdO, spdE, colO, colE, rxO, rxE;
	logic [1:0] bRsp, rRsp, mac = 2'h0, autoL = 2'h0, lineMode;
	logic rxd3 = 0, fibre = 0, sd = 0, spdW, colW, rxW;
	logic [2:0] gi;
	plm_pkg::plm_phy_t phy = '0;
	plm_pkg::plm_func_t strap = 8'h04;
	int errors = 0, checked = 0, fl, fs, fc, fr, go, ge, lr, lx, n;
	plm_pin_mux #(.BLINK_HALF(4)) dut (.core_clk(core_clk), .reset(reset), .clkEn(en),
		.s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awRdy), .s_axi_wdata(wD),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wV), .s_axi_wready(wRdy), .s_axi_bresp(bRsp),
		.s_axi_bvalid(bV), .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV),
		.s_axi_arready(arRdy), .s_axi_rdata(rD), .s_axi_rresp(rRsp), .s_axi_rvalid(rV),
		.s_axi_rready(rR), .phy(phy), .macMode(mac), .autoLine(autoL), .strapFunc(strap),
		.rxData3(rxd3), .link_indicator_pin(lnkPin), .speed_indicator_pin_in(spdW),
		.speed_indicator_pin_out(spdO), .speed_indicator_pin_oe(spdE), .colPinIn(colW),
		.colPinOut(colO), .colPinOe(colE), .rxd3PinIn(rxW), .rxd3PinOut(rxO),
		.rxd3PinOe(rxE), .lineMode(lineMode), .signalDetect(sdet));
	plm_board board (.spdOut(spdO), .spdOe(spdE), .colOut(colO), .colOe(colE), .rxdOut(rxO),
		.rxdOe(rxE), .fibre(fibre), .sdLevel(sd), .spdWire(spdW), .colWire(colW),
		.rxdWire(rxW));
	initial forever #2.5 core_clk = ~core_clk;
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checked++;
		if (got !== ex) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// handshakes decided at the falling edge, taken at the next rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, tb;
		logic [1:0] rs;
		@(posedge core_clk);
		awA <= a; awV <= 1; wD <= d; wV <= 1; bR <= 1;
		do begin
			@(negedge core_clk);
			ta = awV & awRdy; tw = wV & wRdy; tb = bV; rs = bRsp;
			@(posedge core_clk);
			if (ta) awV <= 0;
			if (tw) wV <= 0;
		end while (!tb);
		bR <= 0;
		chk("bresp", er, rs);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tv;
		@(posedge core_clk);
		arA <= a; arV <= 1; rR <= 1;
		do begin
			@(negedge core_clk);
			ta = arV & arRdy; tv = rV; d = rD; r = rRsp;
			@(posedge core_clk);
			if (ta) arV <= 0;
		end while (!tv);
		rR <= 0;
	endtask
	function automatic int fw();
		return fl | fs << plm_pkg::FLD_SPD | fc << plm_pkg::FLD_COL | fr << plm_pkg::FLD_RXD;
	endfunction
	// pins are looked at mid-cycle, away from the edge that launches them
	task automatic pins();
		logic fx, coll, eo, sw, cw, rw;
		@(negedge core_clk);
		fx = lx == 3;
		coll = fc == 0 || (fc == 1 && mac == plm_pkg::MAC_MII && !phy.fullDuplex);
		eo = fx ? 0 : (fs == 1 ? 1 : (fs == 2 ? ge[0] : 0));
		// expected wire levels, released pins at their pulls, for the status read
		sw = eo ? (fs == 1 ? phy.linkUp & phy.speed100 : go[0]) : fx & sd;
		cw = fc != 2 ? (coll ? !phy.fullDuplex & phy.txActive & phy.rxActive : phy.linkUp) :
			(ge[1] ? go[1] : 1'b1);
		rw = mac != plm_pkg::MAC_RMII ? rxd3 : (fr == 1 ? phy.linkUp : fr == 2 && ge[2] && go[2]);
		gi = {rw, cw, sw};
		chk("lineMode", lx, lineMode);
		if (fl == 0) chk("link", phy.linkUp, lnkPin);
		chk("spdOe", eo, spdE);
		if (eo) chk("spdOut", fs == 1 ? phy.linkUp & phy.speed100 : go[0], spdO);
		if (fx) chk("sigDetect", sd, sdet);
		if (fc == 2) chk("colOe", ge[1], colE);
		if (fc == 2 && ge[1]) chk("colGpio", go[1], colO);
		if (fc != 2 && coll) chk("coll", !phy.fullDuplex & phy.txActive & phy.rxActive, colO);
		if (fc != 2) chk("colOe", 1, colE);
		if (fc == 1 && !coll) chk("colLed", phy.linkUp, colO);
		if (mac != plm_pkg::MAC_RMII) chk("rxdKeepOe", 1, rxE);
		if (mac != plm_pkg::MAC_RMII) chk("rxData", rxd3, rxO);
		else if (fr == 1) chk("rxdLed", phy.linkUp, rxO);
		else if (fr == 2) chk("rxdOe", ge[2], rxE);
		if (mac == plm_pkg::MAC_RMII && fr == 2 && ge[2]) chk("rxdGpio", go[2], rxO);
	endtask
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int la;
		n = $urandom(24277);
		repeat (10) @(posedge core_clk);
		reset <= 0;
		fl = 0; fs = 1; fc = 0; fr = 0; go = 0; ge = 0; lr = 0; lx = 0;
		repeat (4) @(posedge core_clk);
		pins();
		@(posedge core_clk);
		for (int i = 0; i < 81; i++) begin
			fs = i % 3; fc = i / 3 % 3; fr = i / 9 % 3; lr = i % 4;
			go = $urandom % 8; ge = $urandom % 8; la = $urandom % 4;
			lx = (lr == 0) ? la : lr;
			mac <= 2'(i / 27); autoL <= 2'(la); fibre <= (lx == 3);
			rxd3 <= 1'($urandom); sd <= 1'($urandom);
			phy <= plm_pkg::plm_phy_t'(6'($urandom) & (i / 27 == 1 ? 6'h39 : 6'h3F));
			wr(plm_pkg::ADDR_FUNC, fw(), plm_pkg::RESP_OKAY);
			wr(plm_pkg::ADDR_GPIO_OUT, go, plm_pkg::RESP_OKAY);
			wr(plm_pkg::ADDR_GPIO_OE, ge, plm_pkg::RESP_OKAY);
			wr(plm_pkg::ADDR_LINE, lr, plm_pkg::RESP_OKAY);
			repeat (8) @(posedge core_clk);
			pins();
			rd(plm_pkg::ADDR_FUNC, d, r);
			chk("func", fw(), d & 32'hFF);
			rd(plm_pkg::ADDR_STATUS, d, r);
			chk("status", lx << 5 | gi << 2 | phy.linkUp << 1 | phy.speed100 |
				(lx == 3 ? sd << 7 : 0), d);
		end
		wr(8'h14, 32'h5, plm_pkg::RESP_DECERR);
		rd(8'h14, d, r);
		chk("rresp", plm_pkg::RESP_DECERR, r);
		chk("rdata", 32'h0, d);
		// activity blink with a shortened half period of four cycles
		fl = 1; fs = 0; fc = 0; fr = 0;
		mac <= plm_pkg::MAC_MII;
		phy <= plm_pkg::plm_phy_t'(6'h20);
		wr(plm_pkg::ADDR_FUNC, fw(), plm_pkg::RESP_OKAY);
		repeat (12) @(posedge core_clk);
		@(negedge core_clk);
		chk("actIdle", 1, lnkPin);
		@(posedge core_clk);
		phy <= plm_pkg::plm_phy_t'(6'h24);
		@(posedge core_clk);
		phy <= plm_pkg::plm_phy_t'(6'h20);
		n = 0;
		repeat (16) begin
			@(negedge core_clk);
			n += (lnkPin === 1'b0);
		end
		chk("blinkOff", 4, n);
		chk("actAfter", 1, lnkPin);
		// link drops while the enable is low: pin must hold until it returns
		@(posedge core_clk);
		en <= 0;
		phy <= plm_pkg::plm_phy_t'(6'h00);
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		chk("freeze", 1, lnkPin);
		@(posedge core_clk);
		en <= 1;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		chk("thaw", 0, lnkPin);
		end_of_test();
	end
	initial begin
		#100000;
		errors++;
		end_of_test();
	end
	task automatic end_of_test();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
endmodule
`default_nettype wire
